// File: exec_unit_model.sv
// ************************************************************
// Execution unit and storage cycle control model
// ************************************************************
module exec_unit_model
   import storage_key_pkg::*;
(
   input  wire logic             pclk,
   output logic                  psw_load,
   output logic [PSW_W-1:0]      psw_new,
   output stor_req_s             stor_req,
   input  wire stor_res_s        stor_res,
   output setkey_req_s           setkey_req,
   input  wire logic             setkey_done,
   input  wire prog_int_s        prog_int
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      psw_load   = 1'b0;
      psw_new    = '0;
      stor_req   = '0;
      setkey_req = '0;
   end

   // Whole status word replaced in one pulse
   task automatic load_psw(input logic [PSW_W-1:0] w);
      @(posedge pclk);
      psw_load <= 1'b1;
      psw_new  <= w;
      @(posedge pclk);
      psw_load <= 1'b0;
      psw_new  <= ~w;
   endtask : load_psw

   // Idle fields show the inverse so a stale value is never reused
   task automatic stor_cycle(input logic m, input logic [ADDR_W-1:0] a,
                             output stor_res_s r, output prog_int_s p);
      r = '0;
      p = '0;
      @(posedge pclk);
      stor_req <= '{valid: 1'b1, modify: m, addr: a};
      @(posedge pclk);
      stor_req <= '{valid: 1'b0, modify: ~m, addr: ~a};
      repeat (6) begin
         #1;
         if (stor_res.done === 1'b1) begin
            r = stor_res;
            p = prog_int;
         end
         @(posedge pclk);
      end
   endtask : stor_cycle

   task automatic set_key(input logic [GR_W-1:0] kr, input logic [GR_W-1:0] ar,
                          output logic d, output prog_int_s p);
      d = 1'b0;
      p = '0;
      @(posedge pclk);
      setkey_req <= '{valid: 1'b1, key_reg: kr, addr_reg: {ar[31:4], 4'h0}};
      @(posedge pclk);
      setkey_req <= '{valid: 1'b0, key_reg: ~kr, addr_reg: ~ar};
      repeat (4) begin
         #1;
         if (setkey_done === 1'b1) d = 1'b1;
         if (prog_int.valid === 1'b1) p = prog_int;
         @(posedge pclk);
      end
   endtask : set_key
endmodule : exec_unit_model

// File: key_ram.sv
module key_ram #(
   parameter int AW = 13,
   parameter int DW = 4
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);

   logic [DW-1:0] mem [2**AW];
   logic [DW-1:0] rdata_ff;

   // ************************************************************
   // Write port
   // ************************************************************
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // ************************************************************
   // Registered read, returns the old word on a same-cycle write
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= mem[raddr];
      end
   end

   assign rdata = rdata_ff;

endmodule : key_ram

// File: storage_key_pkg.sv
package storage_key_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int PSW_W      = 64;
   localparam int GR_W       = 32;
   localparam int ADDR_W     = 24;
   localparam int KEY_W      = 4;
   localparam int BLK_AW     = 13;
   localparam int CODE_W     = 16;
   localparam int PADDR_W    = 12;
   localparam int ST_W       = 3;

   // ************************************************************
   // Field positions (bit 0 of a word is its most significant bit)
   // ************************************************************
   localparam int PSW_PKEY_LSB = 52;   // word bits 8..11
   localparam int PSW_PROB_BIT = 48;   // word bit 15
   localparam int GR_KEY_LSB   = 4;    // word bits 24..27
   localparam int GR_BLK_LSB   = 11;   // word bits 8..20

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [PADDR_W-1:0] REG_STATUS    = 12'h000;
   localparam logic [PADDR_W-1:0] REG_MASK      = 12'h004;
   localparam logic [PADDR_W-1:0] REG_VIOL_ADDR = 12'h008;
   localparam logic [PADDR_W-1:0] REG_VIOL_KEYS = 12'h00C;
   localparam logic [PADDR_W-1:0] REG_CUR_PSW   = 12'h010;

   // Status and mask bit positions
   localparam int ST_PROT   = 0;
   localparam int ST_PRIV   = 1;
   localparam int ST_KEYSET = 2;

   // ************************************************************
   // Reset values and interruption codes
   // ************************************************************
   localparam logic [ST_W-1:0]   MASK_RST  = 3'h0;
   localparam logic [PSW_W-1:0]  PSW_RST   = 64'h0000_0000_0000_0000;
   localparam logic [CODE_W-1:0] CODE_NONE = 16'h0000;
   localparam logic [CODE_W-1:0] CODE_PRIV = 16'h0002;
   localparam logic [CODE_W-1:0] CODE_PROT = 16'h0004;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic              valid;
      logic              modify;
      logic [ADDR_W-1:0] addr;
   } stor_req_s;

   typedef struct packed {
      logic done;
      logic write_ok;
      logic prot_exc;
   } stor_res_s;

   typedef struct packed {
      logic            valid;
      logic [GR_W-1:0] key_reg;
      logic [GR_W-1:0] addr_reg;
   } setkey_req_s;

   typedef struct packed {
      logic              valid;
      logic [CODE_W-1:0] code;
   } prog_int_s;

endpackage : storage_key_pkg

// File: storage_key_protection.sv
// Summary of operation
// - One four-bit key per 2048-byte block
// - Protection key is status word bits 8-11
// - Compare keys on every modification cycle
// - Match if equal or either zero, else exception
// - Suppress the write on protection exception
// - Modification cycle writes new data, not regeneration
// - Fetch cycles never raise protection exception
// - Report protection code for old status word
// - Set-key is register format, supervisor only
// - Set-key updates exactly one block key
// - New key from first register bits 24-27
// - Block from second register bits 8-20
// - Key changes only on whole word replace
// - Set-key in problem state raises privileged exception
module storage_key_protection
   import storage_key_pkg::*;
#(
   parameter int BLK_BITS = BLK_AW
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               psw_load,
   input  wire logic [PSW_W-1:0]   psw_new,
   input  wire stor_req_s          stor_req,
   output stor_res_s               stor_res,
   input  wire setkey_req_s        setkey_req,
   output logic                    setkey_done,
   output prog_int_s               prog_int,
   output logic                    irq
);

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [BLK_BITS-1:0] blk_index(input logic [GR_W-1:0] v);
      blk_index = v[GR_BLK_LSB +: BLK_BITS];
   endfunction : blk_index

   function automatic logic keys_match(input logic [KEY_W-1:0] a,
                                       input logic [KEY_W-1:0] b);
      keys_match = (a == b) || (a == '0) || (b == '0);
   endfunction : keys_match

   // ************************************************************
   // Current status word
   // ************************************************************
   logic [PSW_W-1:0] psw_ff;
   logic [KEY_W-1:0] prot_key;
   logic             prob_state;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psw_ff <= PSW_RST;
      end else if (psw_load) begin
         psw_ff <= psw_new;
      end
   end

   assign prot_key   = psw_ff[PSW_PKEY_LSB +: KEY_W];
   assign prob_state = psw_ff[PSW_PROB_BIT];

   // ************************************************************
   // Key array
   // ************************************************************
   logic                ram_we;
   logic [BLK_BITS-1:0] ram_waddr;
   logic [KEY_W-1:0]    ram_wdata;
   logic [BLK_BITS-1:0] ram_raddr;
   logic [KEY_W-1:0]    ram_rdata;

   assign ram_we    = setkey_req.valid && !prob_state;
   assign ram_waddr = blk_index(setkey_req.addr_reg);
   assign ram_wdata = setkey_req.key_reg[GR_KEY_LSB +: KEY_W];
   assign ram_raddr = blk_index({{(GR_W-ADDR_W){1'b0}}, stor_req.addr});

   key_ram #(
      .AW (BLK_BITS),
      .DW (KEY_W)
   ) u_keys (
      .clk   (pclk),
      .rst_n (presetn),
      .we    (ram_we),
      .waddr (ram_waddr),
      .wdata (ram_wdata),
      .raddr (ram_raddr),
      .rdata (ram_rdata)
   );

   // ************************************************************
   // Check stage: holds the request while its key is read
   // ************************************************************
   logic              chk_valid_ff;
   logic              chk_modify_ff;
   logic [ADDR_W-1:0] chk_addr_ff;
   logic [KEY_W-1:0]  chk_pkey_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chk_valid_ff  <= 1'b0;
         chk_modify_ff <= 1'b0;
         chk_addr_ff   <= '0;
         chk_pkey_ff   <= '0;
      end else begin
         chk_valid_ff  <= stor_req.valid;
         chk_modify_ff <= stor_req.valid && stor_req.modify;
         chk_addr_ff   <= stor_req.addr;
         chk_pkey_ff   <= prot_key;
      end
   end

   logic violation;

   // Only modification cycles are compared
   assign violation = chk_modify_ff && !keys_match(chk_pkey_ff, ram_rdata);

   // ************************************************************
   // Storage cycle answer
   // ************************************************************
   logic done_ff;
   logic write_ok_ff;
   logic prot_exc_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_ff     <= 1'b0;
         write_ok_ff <= 1'b0;
         prot_exc_ff <= 1'b0;
      end else begin
         done_ff     <= chk_valid_ff;
         write_ok_ff <= chk_modify_ff && !violation;
         prot_exc_ff <= violation;
      end
   end

   assign stor_res.done     = done_ff;
   assign stor_res.write_ok = write_ok_ff;
   assign stor_res.prot_exc = prot_exc_ff;

   // ************************************************************
   // Set-key answer
   // ************************************************************
   logic setkey_done_ff;
   logic priv_exc_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setkey_done_ff <= 1'b0;
         priv_exc_ff    <= 1'b0;
      end else begin
         setkey_done_ff <= ram_we;
         priv_exc_ff    <= setkey_req.valid && prob_state;
      end
   end

   assign setkey_done = setkey_done_ff;

   // ************************************************************
   // Program interrupt request with interruption code
   // ************************************************************
   logic              pint_valid_ff;
   logic [CODE_W-1:0] pint_code_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pint_valid_ff <= 1'b0;
         pint_code_ff  <= CODE_NONE;
      end else begin
         pint_valid_ff <= violation || (setkey_req.valid && prob_state);
         if (violation) begin
            pint_code_ff <= CODE_PROT;
         end else if (setkey_req.valid && prob_state) begin
            pint_code_ff <= CODE_PRIV;
         end
      end
   end

   assign prog_int.valid = pint_valid_ff;
   assign prog_int.code  = pint_code_ff;

   // ************************************************************
   // Violation capture for software
   // ************************************************************
   logic [ADDR_W-1:0] viol_addr_ff;
   logic [KEY_W-1:0]  viol_pkey_ff;
   logic [KEY_W-1:0]  viol_skey_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         viol_addr_ff <= '0;
         viol_pkey_ff <= '0;
         viol_skey_ff <= '0;
      end else if (violation) begin
         viol_addr_ff <= chk_addr_ff;
         viol_pkey_ff <= chk_pkey_ff;
         viol_skey_ff <= ram_rdata;
      end
   end

   // ************************************************************
   // APB slave
   // ************************************************************
   logic            setup;
   logic            access;
   logic            mapped;
   logic [31:0]     rd_word;
   logic [31:0]     prdata_ff;
   logic            slverr_ff;
   logic [ST_W-1:0] status_ff;
   logic [ST_W-1:0] mask_ff;

   assign setup  = psel && !penable;
   assign access = psel && penable;
   assign mapped = (paddr == REG_STATUS) || (paddr == REG_MASK) ||
                   (paddr == REG_VIOL_ADDR) || (paddr == REG_VIOL_KEYS) ||
                   (paddr == REG_CUR_PSW);

   always_comb begin
      rd_word = '0;
      case (paddr)
         REG_STATUS:    rd_word[ST_W-1:0]   = status_ff;
         REG_MASK:      rd_word[ST_W-1:0]   = mask_ff;
         REG_VIOL_ADDR: rd_word[ADDR_W-1:0] = viol_addr_ff;
         REG_VIOL_KEYS: rd_word[2*KEY_W-1:0] = {viol_pkey_ff, viol_skey_ff};
         REG_CUR_PSW:   rd_word[KEY_W:0]     = {prob_state, prot_key};
         default:       rd_word = '0;
      endcase
   end

   // Read data is captured in the setup cycle so the access phase needs no wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
         slverr_ff <= 1'b0;
      end else if (setup) begin
         prdata_ff <= pwrite ? 32'h0000_0000 : rd_word;
         slverr_ff <= !mapped;
      end
   end

   assign pready  = 1'b1;
   assign prdata  = prdata_ff;
   assign pslverr = access && slverr_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff <= MASK_RST;
      end else if (access && pwrite && (paddr == REG_MASK)) begin
         mask_ff <= pwdata[ST_W-1:0];
      end
   end

   // ************************************************************
   // Sticky status, cleared by read; a new event beats the clear
   // ************************************************************
   logic [ST_W-1:0] st_set;
   logic [ST_W-1:0] st_clr;

   always_comb begin
      st_set            = '0;
      st_set[ST_PROT]   = violation;
      st_set[ST_PRIV]   = setkey_req.valid && prob_state;
      st_set[ST_KEYSET] = ram_we;
   end

   // Only bits already returned to software are cleared
   assign st_clr = (access && !pwrite && (paddr == REG_STATUS)) ?
                   prdata_ff[ST_W-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_ff <= '0;
      end else begin
         status_ff <= (status_ff & ~st_clr) | st_set;
      end
   end

   assign irq = |(status_ff & mask_ff);

   // ************************************************************
   // Assertions
   // ************************************************************
   a_fetch_no_exc : assert property (@(posedge pclk) disable iff (!presetn)
      stor_req.valid && !stor_req.modify |-> ##2 (stor_res.done && !stor_res.prot_exc))
      else $error("fetch cycle raised a protection exception");

   a_exc_no_write : assert property (@(posedge pclk) disable iff (!presetn)
      stor_res.prot_exc |-> !stor_res.write_ok && stor_res.done)
      else $error("write allowed on protection exception");

   a_zero_key_ok : assert property (@(posedge pclk) disable iff (!presetn)
      stor_req.valid && stor_req.modify && (prot_key == '0)
      |-> ##2 (stor_res.write_ok && !stor_res.prot_exc))
      else $error("zero protection key was refused");

   a_equal_keys_ok : assert property (@(posedge pclk) disable iff (!presetn)
      chk_modify_ff && (ram_rdata == chk_pkey_ff) |=> stor_res.write_ok)
      else $error("equal keys were refused");

   a_mismatch_int : assert property (@(posedge pclk) disable iff (!presetn)
      stor_res.prot_exc |-> prog_int.valid && (prog_int.code == CODE_PROT))
      else $error("protection exception without protection code");

   a_priv_refused : assert property (@(posedge pclk) disable iff (!presetn)
      setkey_req.valid && prob_state
      |=> !setkey_done && prog_int.valid && status_ff[ST_PRIV])
      else $error("set-key in problem state not refused");

   a_setkey_done : assert property (@(posedge pclk) disable iff (!presetn)
      setkey_req.valid && !prob_state |=> setkey_done && !priv_exc_ff)
      else $error("supervisor set-key not performed");

   a_pkey_stable : assert property (@(posedge pclk) disable iff (!presetn)
      !psw_load |=> $stable(prot_key))
      else $error("protection key changed without status word load");

   a_setkey_reads : assert property (@(posedge pclk) disable iff (!presetn)
      setkey_req.valid && !prob_state && !psw_load ##1
      stor_req.valid && stor_req.modify && !psw_load &&
      (ram_raddr == $past(ram_waddr)) && !ram_we && (prot_key != '0) &&
      ($past(ram_wdata) == prot_key)
      |-> ##2 stor_res.write_ok)
      else $error("key written by set-key not used by check");

   a_irq_level : assert property (@(posedge pclk) disable iff (!presetn)
      stor_res.prot_exc && mask_ff[ST_PROT] |-> irq)
      else $error("unmasked protection event without interrupt");

endmodule : storage_key_protection

// File: storage_key_protection_test.sv
module storage_key_protection_test
   import storage_key_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ************************************************************
   // Signals
   // ************************************************************
   logic               pclk    = 1'b0;
   logic               presetn = 1'b0;
   logic [PADDR_W-1:0] paddr;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic               psw_load;
   logic [PSW_W-1:0]   psw_new;
   stor_req_s          stor_req;
   stor_res_s          stor_res;
   setkey_req_s        setkey_req;
   logic               setkey_done;
   prog_int_s          prog_int;
   logic               irq;
   logic [31:0]        rdat;
   logic               rerr;
   int                 error_cnt = 0;
   int                 cmp_count = 0;

   always #2.5 pclk = ~pclk;

   storage_key_protection dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psw_load(psw_load), .psw_new(psw_new), .stor_req(stor_req),
      .stor_res(stor_res), .setkey_req(setkey_req), .setkey_done(setkey_done),
      .prog_int(prog_int), .irq(irq)
   );

   exec_unit_model cpu (
      .pclk(pclk), .psw_load(psw_load), .psw_new(psw_new), .stor_req(stor_req),
      .stor_res(stor_res), .setkey_req(setkey_req), .setkey_done(setkey_done),
      .prog_int(prog_int)
   );

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic finish_test;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [PADDR_W-1:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000, rdat, rerr);
      chk(nm, e, rdat);
      chk("pslverr", 32'h0000_0000, rerr);
   endtask : rd

   task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rdat, rerr);
   endtask : wr

   task automatic mod(input logic m, input logic [ADDR_W-1:0] a, input logic ok,
                      input logic exc);
      stor_res_s r;
      prog_int_s p;
      cpu.stor_cycle(m, a, r, p);
      chk("done", 32'h0000_0001, r.done);
      chk("write_ok", ok, r.write_ok);
      chk("prot_exc", exc, r.prot_exc);
      chk("prog_int", exc, p.valid);
      if (exc) chk("code", CODE_PROT, p.code);
   endtask : mod

   task automatic skey(input logic [GR_W-1:0] kr, input logic [GR_W-1:0] ar, input logic sup);
      logic      d;
      prog_int_s p;
      cpu.set_key(kr, ar, d, p);
      chk("setkey_done", sup, d);
      chk("priv_int", !sup, p.valid);
      if (!sup) chk("priv_code", CODE_PRIV, p.code);
   endtask : skey

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      paddr   = '0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      pwdata  = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(REG_MASK, {29'h0, MASK_RST}, "mask");
      rd(REG_STATUS, 32'h0000_0000, "status");
      chk("irq", 32'h0000_0000, irq);
      apb(1'b0, 12'h020, 32'h0000_0000, rdat, rerr);
      chk("unmapped_err", 32'h0000_0001, rerr);
      chk("unmapped_data", 32'h0000_0000, rdat);
      wr(REG_CUR_PSW, 32'hFFFF_FFFF);
      rd(REG_CUR_PSW, 32'h0000_0000, "cur_psw");
      wr(REG_MASK, 32'hFFFF_FFF8);
      rd(REG_MASK, 32'h0000_0000, "mask");
      skey(32'h1234_5A5F, 32'hFF00_1000, 1'b1);
      skey(32'hABCD_EF6F, 32'h8000_0FF0, 1'b1);
      skey(32'h0000_000F, 32'h0000_1800, 1'b1);
      skey(32'h0000_006F, 32'h00FF_F800, 1'b1);
      skey(32'h0000_00F0, 32'h0000_0000, 1'b1);
      cpu.load_psw(64'h0061_0000_0000_0000);
      rd(REG_CUR_PSW, 32'h0000_0016, "cur_psw");
      mod(1'b1, 24'h000ABC, 1'b1, 1'b0);
      mod(1'b1, 24'h001234, 1'b0, 1'b1);
      rd(REG_VIOL_ADDR, 32'h0000_1234, "viol_addr");
      rd(REG_VIOL_KEYS, 32'h0000_0065, "viol_keys");
      mod(1'b0, 24'h001234, 1'b0, 1'b0);
      mod(1'b1, 24'h001FFC, 1'b1, 1'b0);
      mod(1'b1, 24'hFFF800, 1'b1, 1'b0);
      mod(1'b1, 24'h000010, 1'b0, 1'b1);
      rd(REG_VIOL_KEYS, 32'h0000_006F, "viol_keys");
      skey(32'h0000_0060, 32'h0000_1000, 1'b0);
      mod(1'b1, 24'h001000, 1'b0, 1'b1);
      rd(REG_VIOL_KEYS, 32'h0000_0065, "viol_keys");
      #1;
      chk("irq_masked", 32'h0000_0000, irq);
      wr(REG_MASK, 32'h0000_0001);
      #1;
      chk("irq_set", 32'h0000_0001, irq);
      rd(REG_STATUS, 32'h0000_0007, "status");
      #1;
      chk("irq_clear", 32'h0000_0000, irq);
      rd(REG_STATUS, 32'h0000_0000, "status");
      cpu.load_psw(64'h0000_0000_0000_0000);
      mod(1'b1, 24'h001234, 1'b1, 1'b0);
      cpu.load_psw(64'h0030_0000_0000_0000);
      // Set-key followed at once by a write to the same block
      fork
         skey(32'h0000_0030, 32'h0000_1000, 1'b1);
         begin
            @(posedge pclk);
            mod(1'b1, 24'h001234, 1'b1, 1'b0);
         end
      join
      mod(1'b1, 24'h000010, 1'b0, 1'b1);
      rd(REG_VIOL_KEYS, 32'h0000_003F, "viol_keys");
      #1;
      chk("irq_prot", 32'h0000_0001, irq);
      rd(REG_STATUS, 32'h0000_0005, "status");
      finish_test;
   end

   // ************************************************************
   // Watchdog
   // ************************************************************
   initial begin
      #20000;
      error_cnt++;
      finish_test;
   end
endmodule : storage_key_protection_test
